//--- hdl/ieflag_consts.vh
`ifndef IEFLAG_CONSTS_VH
`define IEFLAG_CONSTS_VH
// register byte addresses
`define IEF_ADDR_GCTL      12'h000
`define IEF_ADDR_PFLAG1    12'h004
`define IEF_ADDR_PFLAG2    12'h008
`define IEF_ADDR_PMASK1    12'h00c
`define IEF_ADDR_PMASK2    12'h010
`define IEF_ADDR_MASTER    12'h014
`define IEF_ADDR_SERVICE   12'h018
// global control bit positions
`define IEF_GC_CHG_ST      0
`define IEF_GC_EDGE_ST     1
`define IEF_GC_OVF_ST      2
`define IEF_GC_CHG_EN      3
`define IEF_GC_EDGE_EN     4
`define IEF_GC_OVF_EN      5
`define IEF_GC_PERI_EN     6
// writable bits of global control and of flag 2 and mask 2, and the reset byte
`define IEF_GC_WMASK       8'h7f
`define IEF_PF2_WMASK      8'h01
`define IEF_RESET_BYTE     8'h00
// service request codes
`define IEF_SVC_NONE       2'h0
`define IEF_SVC_EXT        2'h1
`define IEF_SVC_PERI       2'h2
// vector locations of the external handler
`define IEF_VEC_EXT_LO     16'h0002
`define IEF_VEC_EXT_HI     16'h0003
`endif

//--- hdl/ieflag_sync.v
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for a bus of pin levels
module ieflag_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // first stage feeds only the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
    assign q = sync_ff;
endmodule
`default_nettype wire

//--- hdl/ieflag_unit.v
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ieflag_consts.vh"
module ieflag_unit #(
    parameter AW = 12
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    input  wire [3:0]    pstrb,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          irq_n,
    input  wire [7:0]    data_port,
    input  wire          base_timer_ovf,
    input  wire [7:0]    peri_event_one,
    input  wire          capture_compare_two_evt,
    input  wire          token_done,
    output wire          svc_take,
    output reg  [1:0]    svc_kind_ff,
    output wire [15:0]   ext_vec_lo,
    output wire [15:0]   ext_vec_hi,
    output wire          peri_req,
    output wire          ext_req
);
    reg  [7:0] gctl_ff;
    reg  [7:0] pflag1_ff;
    reg  [7:0] pflag2_ff;
    reg  [7:0] pmask1_ff;
    reg  [7:0] pmask2_ff;
    reg        master_ff;
    reg        irq_s_prev_ff;
    reg  [4:0] port_prev_ff;
    reg  [7:0] nxt_gctl;
    reg  [7:0] nxt_pflag1;
    reg  [7:0] nxt_pflag2;
    reg        nxt_master;
    wire       irq_s_n;
    wire [4:0] port_s;
    wire       wr_en;
    wire       rd_en;
    wire       hit;
    wire [7:0] wbyte;
    wire       chg_evt;
    wire       edge_evt;
    wire       glob_req;

    // byte write with lane 0 strobe, returns merged value
    function [7:0] lane0;
        input [7:0] old;
        input [7:0] wd;
        input       stb;
        begin
            lane0 = stb ? wd : old;
        end
    endfunction

    // hardware set wins over a software clear in the same cycle
    function [7:0] flag_next;
        input [7:0] old;
        input [7:0] wd;
        input       wr;
        input [7:0] evt;
        begin
            flag_next = (wr ? wd : old) | evt;
        end
    endfunction

    // synchronise request pin, port bits 4..7 and port bit 0
    ieflag_sync #(
        .W (6)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({irq_n, data_port[7:4], data_port[0]}),
        .q       ({irq_s_n, port_s})
    );

    // apb decode: zero wait states, unmapped reads zero and error
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign hit     = (paddr == `IEF_ADDR_GCTL)   | (paddr == `IEF_ADDR_PFLAG1) |
                     (paddr == `IEF_ADDR_PFLAG2) | (paddr == `IEF_ADDR_PMASK1) |
                     (paddr == `IEF_ADDR_PMASK2) | (paddr == `IEF_ADDR_MASTER) |
                     (paddr == `IEF_ADDR_SERVICE);
    assign pslverr = psel & penable & ~hit;
    assign wbyte   = pwdata[7:0];

    // event detectors on synchronised port levels
    // port change
    assign chg_evt  = (port_s[4:1] != port_prev_ff[4:1]);
    assign edge_evt = (port_s[0] != port_prev_ff[0]);

    assign glob_req = (gctl_ff[`IEF_GC_CHG_ST]  & gctl_ff[`IEF_GC_CHG_EN]) |
                      (gctl_ff[`IEF_GC_EDGE_ST] & gctl_ff[`IEF_GC_EDGE_EN]) |
                      (gctl_ff[`IEF_GC_OVF_ST]  & gctl_ff[`IEF_GC_OVF_EN]);

    assign peri_req = master_ff & gctl_ff[`IEF_GC_PERI_EN] &
                      (|(pflag1_ff & pmask1_ff) | |(pflag2_ff & pmask2_ff) | glob_req);

    assign ext_req  = master_ff & ~irq_s_n;

    assign svc_take = token_done & (ext_req | (master_ff & glob_req) | peri_req);

    assign ext_vec_lo = `IEF_VEC_EXT_LO;
    assign ext_vec_hi = `IEF_VEC_EXT_HI;

    // next state of registers
    always @* begin
        nxt_gctl   = gctl_ff;
        nxt_pflag1 = pflag1_ff;
        nxt_pflag2 = pflag2_ff;
        nxt_master = master_ff;
        if (wr_en && paddr == `IEF_ADDR_GCTL) begin
            nxt_gctl = lane0(gctl_ff, wbyte, pstrb[0]) & `IEF_GC_WMASK;
        end
        nxt_gctl[`IEF_GC_CHG_ST]  = nxt_gctl[`IEF_GC_CHG_ST]  | chg_evt;
        nxt_gctl[`IEF_GC_EDGE_ST] = nxt_gctl[`IEF_GC_EDGE_ST] | edge_evt;
        nxt_gctl[`IEF_GC_OVF_ST]  = nxt_gctl[`IEF_GC_OVF_ST]  | base_timer_ovf;
        nxt_pflag1 = flag_next(pflag1_ff, wbyte,
                               wr_en && paddr == `IEF_ADDR_PFLAG1 && pstrb[0], peri_event_one);
        nxt_pflag2 = flag_next(pflag2_ff, wbyte,
                               wr_en && paddr == `IEF_ADDR_PFLAG2 && pstrb[0],
                               {7'h00, capture_compare_two_evt}) & `IEF_PF2_WMASK;
        if (wr_en && paddr == `IEF_ADDR_MASTER && pstrb[0]) begin
            nxt_master = wbyte[0];
        end
        // taking a request clears master enable
        if (svc_take) begin
            nxt_master = 1'b0;
        end
    end

    // register state
    // all clear on reset except the request pin history, which resets high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gctl_ff       <= `IEF_RESET_BYTE;
            pflag1_ff     <= `IEF_RESET_BYTE;
            pflag2_ff     <= `IEF_RESET_BYTE;
            pmask1_ff     <= `IEF_RESET_BYTE;
            pmask2_ff     <= `IEF_RESET_BYTE;
            master_ff     <= 1'b0;
            irq_s_prev_ff <= 1'b1;
            port_prev_ff  <= 5'h00;
        end else begin
            gctl_ff       <= nxt_gctl;
            pflag1_ff     <= nxt_pflag1;
            pflag2_ff     <= nxt_pflag2;
            master_ff     <= nxt_master;
            irq_s_prev_ff <= irq_s_n;
            port_prev_ff  <= port_s;
            if (wr_en && paddr == `IEF_ADDR_PMASK1) begin
                pmask1_ff <= lane0(pmask1_ff, wbyte, pstrb[0]);
            end
            if (wr_en && paddr == `IEF_ADDR_PMASK2) begin
                pmask2_ff <= lane0(pmask2_ff, wbyte, pstrb[0]) & `IEF_PF2_WMASK;
            end
        end
    end

    // kind of last taken request, external has priority
    // separate peripheral handler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_kind_ff <= `IEF_SVC_NONE;
        end else if (svc_take) begin
            svc_kind_ff <= ext_req ? `IEF_SVC_EXT : `IEF_SVC_PERI;
        end
    end

    // read mux
    // flags readable
    always @* begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `IEF_ADDR_GCTL:    prdata = {24'h000000, gctl_ff};
                `IEF_ADDR_PFLAG1:  prdata = {24'h000000, pflag1_ff};
                `IEF_ADDR_PFLAG2:  prdata = {24'h000000, pflag2_ff};
                `IEF_ADDR_PMASK1:  prdata = {24'h000000, pmask1_ff};
                `IEF_ADDR_PMASK2:  prdata = {24'h000000, pmask2_ff};
                `IEF_ADDR_MASTER:  prdata = {31'h00000000, master_ff};
                `IEF_ADDR_SERVICE: prdata = {29'h00000000, irq_s_prev_ff, svc_kind_ff};
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- tb/ieflag_irq_src.sv
`timescale 1ns/1ps
`default_nettype none
module ieflag_irq_src (
    input  wire logic pclk,
    input  wire logic req,
    output var  logic irq_n
);
    always @(posedge pclk) irq_n <= ~req;
    // pulled high while released
    initial irq_n = 1'b1;
endmodule
`default_nettype wire

//--- tb/ieflag_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ieflag_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        token_done,
    input wire logic        svc_take,
    input wire logic [1:0]  svc_kind_ff,
    input wire logic        ext_req,
    input wire logic [15:0] ext_vec_lo,
    input wire logic [15:0] ext_vec_hi
);
    logic blk_ff;
    wire  rd    = psel && penable && !pwrite;
    wire  wr_on = psel && penable && pwrite && paddr == 12'h014;
    // held off from reset or a take until master is written
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) blk_ff <= 1'b1;
        else if (svc_take || wr_on) blk_ff <= svc_take;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_TOKEN: assert property (svc_take |-> token_done) else $error("take off token end");
    AST_TAKE: assert property (svc_take |=> !svc_take) else $error("take repeated");
    AST_BLOCK: assert property (blk_ff |-> !svc_take) else $error("take while disabled");
    AST_KEXT: assert property (svc_take && ext_req |=> svc_kind_ff == 2'h1) else $error("bad ext kind");
    AST_KPERI: assert property (svc_take && !ext_req |=> svc_kind_ff == 2'h2) else $error("bad kind");
    AST_VEC: assert property (ext_vec_lo == 16'h0002 && ext_vec_hi == 16'h0003) else $error("bad vector");
    AST_RST: assert property ($rose(presetn) |-> svc_kind_ff == 2'h0) else $error("kind not cleared");
    AST_FLAG2: assert property (rd && paddr == 12'h008 |-> prdata[31:1] == 31'h0) else $error("flag2 bits");
    C_EXT: cover property (svc_take && ext_req);
    C_PERI: cover property (svc_take && !ext_req);
    C_WR: cover property (wr_on);
endmodule
`default_nettype wire

//--- tb/interrupt_enable_flag_mask_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_flag_mask_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite, irq_cmd, tdone, ovf, cc2, pready, peri_req, irq_n;
    logic        pslverr, err_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  port, pev;
    int          mismatches, tests_run, i;
    // software keeps global bit 7 at zero
    logic [27:0] rows [6] = '{{12'h000, 8'h7f, 8'h7f}, {12'h004, 8'ha5, 8'ha5}, {12'h008, 8'hff, 8'h01},
                              {12'h00c, 8'h5a, 8'h5a}, {12'h010, 8'hff, 8'h01}, {12'h01c, 8'hff, 8'h00}};
    ieflag_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_n(irq_n), .data_port(port), .base_timer_ovf(ovf), .peri_event_one(pev),
        .capture_compare_two_evt(cc2), .token_done(tdone), .svc_take(), .svc_kind_ff(),
        .ext_vec_lo(), .ext_vec_hi(), .peri_req(peri_req), .ext_req());
    ieflag_irq_src SRC (.pclk(pclk), .req(irq_cmd), .irq_n(irq_n));
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // apb transfer, starts after an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // token end pulse, take checked 10 ns after the edge
    task automatic tok(input logic e);
        @(posedge pclk);
        tdone <= 1'b1;
        #10 chk(32'(DUT.svc_take), 32'(e));
        @(posedge pclk);
        tdone <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, irq_cmd, tdone, ovf, cc2, presetn} = 8'h0;
        {paddr, pwdata, port, pev} = 60'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            apb(0, rows[i][27:16], 8'h0, r);
            chk(r, 32'h0);
            apb(1, rows[i][27:16], rows[i][15:8], r);
            apb(0, rows[i][27:16], 8'h0, r);
            chk(r, {24'h0, rows[i][7:0]});
            chk(32'(err_q), 32'(i == 5));
            apb(1, rows[i][27:16], 8'h0, r);
        end
        // external request taken once, then held off
        apb(1, 12'h014, 8'h1, r);
        irq_cmd <= 1'b1;
        repeat (5) @(posedge pclk);
        tok(1);
        apb(0, 12'h018, 8'h0, r);
        chk(r, 32'h1);
        tok(0);
        irq_cmd <= 1'b0;
        // port and timer events, enables clear then set
        apb(1, 12'h014, 8'h1, r);
        port <= 8'h11;
        ovf <= 1'b1;
        @(posedge pclk);
        ovf <= 1'b0;
        repeat (4) @(posedge pclk);
        tok(0);
        apb(0, 12'h000, 8'h0, r);
        chk(r, 32'h7);
        apb(1, 12'h000, 8'h3f, r);
        tok(1);
        apb(0, 12'h018, 8'h0, r);
        chk(r, 32'h6);
        // peripheral flags through gate and masks
        apb(1, 12'h000, 8'h0, r);
        apb(1, 12'h014, 8'h1, r);
        apb(1, 12'h00c, 8'h5a, r);
        pev <= 8'h5a;
        cc2 <= 1'b1;
        @(posedge pclk);
        pev <= 8'h0;
        cc2 <= 1'b0;
        apb(0, 12'h004, 8'h0, r);
        chk(r, 32'h5a);
        chk(32'(peri_req), 0);
        apb(1, 12'h000, 8'h40, r);
        #10 chk(32'(peri_req), 1);
        apb(1, 12'h00c, 8'h0, r);
        #10 chk(32'(peri_req), 0);
        apb(1, 12'h010, 8'h1, r);
        #10 chk(32'(peri_req), 1);
        tok(1);
        #10 chk(32'(peri_req), 0);
        apb(1, 12'h008, 8'h0, r);
        apb(0, 12'h008, 8'h0, r);
        chk(r, 32'h0);
        finish_test();
    end
endmodule
bind ieflag_unit ieflag_properties CHK (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .token_done(token_done), .svc_take(svc_take),
    .svc_kind_ff(svc_kind_ff), .ext_req(ext_req), .ext_vec_lo(ext_vec_lo), .ext_vec_hi(ext_vec_hi));
`default_nettype wire
